// ---- design/cmf_pkg.sv ----
// Purpose: Shared constants for the charger mode and fault control block
// Assumes: 100 MHz clock, one 1 us tick derived inside the block
// Notes: Fault codes are a small enumeration reported on a status port
package cmf_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 1;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam int PULSE_US = 128;
  localparam int OVLD_MS = 30;
  localparam int OVLD_US = OVLD_MS * 1000;
  localparam int WDOG_S = 32;
  localparam int WDOG_US = WDOG_S * 1000000;
  localparam int MIN15_S = 900;
  localparam int MIN15_US = MIN15_S * 1000000;

  // ----------------------------------------
  // Operating modes and fault codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    CMF_HIZ = 2'b00,
    CMF_CHARGE = 2'b01,
    CMF_CFG = 2'b11,
    CMF_BOOST = 2'b10
  } cmf_mode_t;

  localparam logic [3:0] FLT_NONE = 4'h0;
  localparam logic [3:0] FLT_TIMER = 4'h1;
  localparam logic [3:0] FLT_SLEEP = 4'h2;
  localparam logic [3:0] FLT_OVP = 4'h3;
  localparam logic [3:0] FLT_POOR = 4'h4;
  localparam logic [3:0] FLT_UVLO = 4'h5;
  localparam logic [3:0] FLT_NOBAT = 4'h6;
  localparam logic [3:0] FLT_THERM = 4'h7;
  localparam logic [3:0] FLT_OVLD = 4'h8;
  localparam logic [3:0] FLT_BAT = 4'h9;
endpackage : cmf_pkg

// ---- design/cmf_timer.sv ----
// Purpose: Microsecond down-counter with restart, used for pulse and timeouts
// Assumes: tick is a one-cycle enable; start wins over counting
// Notes: done is a one-cycle pulse as the count reaches zero
`timescale 1ns/10ps
module cmf_timer #(
  parameter int WIDTH = 32
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic tick,
  input wire logic start,
  input wire logic stop,
  input wire logic [WIDTH-1:0] load,
  output logic running,
  output logic done
);
  logic [WIDTH-1:0] cnt_q;
  logic run_q;
  logic done_q;
  wire last = run_q && tick && (cnt_q <= {{(WIDTH-1){1'b0}}, 1'b1});

  always_ff @(posedge clk) begin
    if (reset || stop) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      done_q <= 1'b0;
    end else if (start) begin
      cnt_q <= load;
      run_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      done_q <= last;
      if (last) begin
        run_q <= 1'b0;
        cnt_q <= '0;
      end else if (run_q && tick) begin
        cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  assign running = run_q;
  assign done = done_q;
endmodule : cmf_timer

// ---- design/cmf_ctrl.sv ----
// Purpose: Mode selection, state pin, boost watchdog and boost fault handling
// Assumes: Analog comparators arrive as asynchronous levels; control bits are
//   same-clock levels and pulses from the register logic
// Notes: Parameter reset and limit lock are flags handed to the register logic
//
// Contract
// - State pin low while charging, if enabled
// - Any fault gives one 128 us low pulse
// - Charge mode faults raise the pulse
// - Boost mode faults raise the pulse
// - Charge inhibit bit disables charging
// - Parameter reset restores defaults, self-clears
// - Mode from operation and hi-z bits
// - Boost without fault, else charge-configure
// - Charge-disable pin high forces hi-z
// - Disable rise resets 15-minute timer only, when not in host mode
// - Lock pin low holds limit defaults
// - First other write locks safety limits
// - Boost from OTG pin or operation bit
// - Light-load boost skips pulses with hysteresis
// - 32 s boost watchdog, kick bit clears
// - Watchdog expiry stops boost, flags fault
// - Output overvoltage stops boost, clears request
// - Overload fault after 30 ms persistence
// - Overload blocks restart until fault cleared
// - Battery limits stop boost, clear request
// - State pin released during healthy boost
// - Fault status frozen until host reads
// - Leave hi-z only when all conditions hold
`timescale 1ns/10ps
module cmf_ctrl
  import cmf_pkg::*;
#(
  parameter int PULSE_US_P = PULSE_US,
  parameter int OVLD_US_P = OVLD_US,
  parameter int WDOG_US_P = WDOG_US,
  parameter int MIN15_US_P = MIN15_US
) (
  input wire logic clk,
  input wire logic reset,
  // Control bits from the register logic
  input wire logic state_pin_enable,
  input wire logic charge_inhibit,
  input wire logic operation_select_bit,
  input wire logic high_impedance_select,
  input wire logic otg_function_enable,
  input wire logic host_mode,
  input wire logic watchdog_kick_bit,
  input wire logic param_reset_bit,
  input wire logic safety_write,
  input wire logic other_write,
  input wire logic status_read,
  input wire logic fault_clear,
  // Pins and analog comparators (asynchronous)
  input wire logic charge_disable_pin,
  input wire logic limit_lock_reset_pin,
  input wire logic otg_pin,
  input wire logic vbus_above_uvlo,
  input wire logic chg_timer_expired,
  input wire logic sleep_det,
  input wire logic vbus_ovp,
  input wire logic bat_ovp,
  input wire logic poor_source,
  input wire logic no_battery,
  input wire logic thermal_shutdown,
  input wire logic output_overload,
  input wire logic bat_above_max,
  input wire logic bat_below_min,
  input wire logic ind_current_low,
  input wire logic boost_node_low,
  // Outputs
  output logic state_pin_out,
  output logic state_pin_oe,
  output logic [1:0] op_mode,
  output logic charge_enable,
  output logic boost_switch_on,
  output logic clear_operation_select,
  output logic watchdog_kick_clear,
  output logic param_reset_clear,
  output logic params_to_default,
  output logic safety_write_enable,
  output logic limits_to_default,
  output logic [3:0] fault_status,
  output logic min15_timer_reset
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam int NSYNC = 16;
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  assign raw = {charge_disable_pin, limit_lock_reset_pin, otg_pin, vbus_above_uvlo,
                chg_timer_expired, sleep_det, vbus_ovp, bat_ovp, poor_source, no_battery,
                thermal_shutdown, output_overload, bat_above_max, bat_below_min,
                ind_current_low, boost_node_low};
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end
  wire cd_s = s2_q[15];
  wire lock_n_s = s2_q[14];
  wire otg_s = s2_q[13];
  wire uvlo_ok_s = s2_q[12];
  wire tmr_s = s2_q[11];
  wire sleep_s = s2_q[10];
  wire ovp_s = s2_q[9] | s2_q[8];
  wire poor_s = s2_q[7];
  wire nobat_s = s2_q[6];
  wire therm_s = s2_q[5];
  wire ovld_s = s2_q[4];
  wire bmax_s = s2_q[3];
  wire bmin_s = s2_q[2];
  wire ilow_s = s2_q[1];
  wire node_low_s = s2_q[0];

  // ----------------------------------------
  // Reference tick
  // ----------------------------------------
  logic [7:0] div_q;
  wire tick = (div_q == 8'(TICK_CYCLES - 1));
  always_ff @(posedge clk) begin
    if (reset || tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // ----------------------------------------
  // Mode selection
  // ----------------------------------------
  cmf_mode_t mode_q;
  cmf_mode_t mode_d;
  logic hiz_q;
  logic ovld_lock_q;
  logic boost_fault;
  logic charge_fault;
  wire boost_req = host_mode && ((otg_s && otg_function_enable) || operation_select_bit);
  wire boosting = (mode_q == CMF_BOOST);
  wire hiz_hold = cd_s || !uvlo_ok_s || high_impedance_select;
  always_ff @(posedge clk) begin
    if (reset) begin
      hiz_q <= 1'b1;
    end else if (hiz_hold) begin
      hiz_q <= 1'b1;
    end else if (!high_impedance_select && cd_s == 1'b0 && uvlo_ok_s) begin
      hiz_q <= 1'b0;
    end
  end

  always_comb begin
    if (hiz_q || cd_s) begin
      mode_d = CMF_HIZ;
    end else if (boost_req && !ovld_lock_q && !bmin_s) begin
      mode_d = boost_fault ? CMF_CFG : CMF_BOOST;
    end else if (!uvlo_ok_s) begin
      mode_d = CMF_HIZ;
    end else if (charge_fault) begin
      mode_d = CMF_CFG;
    end else begin
      mode_d = CMF_CHARGE;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_q <= CMF_HIZ;
    end else begin
      mode_q <= mode_d;
    end
  end
  assign op_mode = mode_q;
  assign charge_enable = (mode_q == CMF_CHARGE) && !charge_inhibit;

  // ----------------------------------------
  // Boost watchdog and overload persistence
  // ----------------------------------------
  logic wd_done;
  logic ov_run;
  logic ov_done;
  logic boost_start_q;
  wire boost_rise = boosting && !boost_start_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      boost_start_q <= 1'b0;
    end else begin
      boost_start_q <= boosting;
    end
  end
  // restart on boost start or kick
  cmf_timer #(.WIDTH(32)) u_wdog (
    .clk(clk), .reset(reset), .tick(tick),
    .start(boost_rise || (boosting && watchdog_kick_bit)),
    .stop(!boosting), .load(32'(WDOG_US_P)),
    .running(), .done(wd_done)
  );
  assign watchdog_kick_clear = watchdog_kick_bit;
  wire ov_start = boosting && ovld_s && !ov_run && !ov_done;
  cmf_timer #(.WIDTH(32)) u_ovld (
    .clk(clk), .reset(reset), .tick(tick),
    .start(ov_start), .stop(!(boosting && ovld_s)), .load(32'(OVLD_US_P)),
    .running(ov_run), .done(ov_done)
  );

  // ----------------------------------------
  // Fault detection
  // ----------------------------------------
  // charge mode fault sources
  wire chg_fault_now = (mode_q != CMF_BOOST) && !hiz_q &&
                       (tmr_s || sleep_s || ovp_s || poor_s || !uvlo_ok_s || nobat_s || therm_s);
  wire bst_fault_now = boosting && (wd_done || ov_done || s2_q[9] || bmax_s || bmin_s || therm_s);
  assign charge_fault = chg_fault_now;
  logic wd_fault_q;
  // Expiry in the same cycle as a host clear must not be lost
  always_ff @(posedge clk) begin
    if (reset) begin
      wd_fault_q <= 1'b0;
    end else if (wd_done) begin
      wd_fault_q <= 1'b1;
    end else if (fault_clear) begin
      wd_fault_q <= 1'b0;
    end
  end
  assign boost_fault = bst_fault_now || wd_fault_q;
  wire any_fault = chg_fault_now || bst_fault_now;
  logic fault_prev_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      fault_prev_q <= 1'b0;
    end else begin
      fault_prev_q <= any_fault;
    end
  end
  wire fault_rise = any_fault && !fault_prev_q;

  // overload lock, set wins over clear
  always_ff @(posedge clk) begin
    if (reset) begin
      ovld_lock_q <= 1'b0;
    end else if (ov_done) begin
      ovld_lock_q <= 1'b1;
    end else if (fault_clear) begin
      ovld_lock_q <= 1'b0;
    end
  end
  assign clear_operation_select = bst_fault_now && !wd_done;

  logic [3:0] code_d;
  logic [3:0] stat_q;
  logic stat_held_q;
  always_comb begin
    if (ov_done) code_d = FLT_OVLD;
    else if (wd_done || tmr_s) code_d = FLT_TIMER;
    else if (ovp_s) code_d = FLT_OVP;
    else if (boosting && (bmax_s || bmin_s)) code_d = FLT_BAT;
    else if (therm_s) code_d = FLT_THERM;
    else if (nobat_s) code_d = FLT_NOBAT;
    else if (!uvlo_ok_s) code_d = FLT_UVLO;
    else if (poor_s) code_d = FLT_POOR;
    else code_d = FLT_SLEEP;
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      stat_q <= FLT_NONE;
      stat_held_q <= 1'b0;
    end else if (fault_rise && !stat_held_q) begin
      stat_q <= code_d;
      stat_held_q <= 1'b1;
    end else if (status_read || fault_clear) begin
      stat_held_q <= 1'b0;
      if (fault_clear) begin
        stat_q <= FLT_NONE;
      end
    end
  end
  assign fault_status = stat_q;

  // ----------------------------------------
  // State pin
  // ----------------------------------------
  logic pulse_run;
  cmf_timer #(.WIDTH(8)) u_pulse (
    .clk(clk), .reset(reset), .tick(tick),
    .start(fault_rise), .stop(1'b0), .load(8'(PULSE_US_P)),
    .running(pulse_run), .done()
  );
  // low only when charging or pulsing
  wire pin_low = pulse_run || (mode_q == CMF_CHARGE && charge_enable && state_pin_enable);
  assign state_pin_out = 1'b0;
  assign state_pin_oe = pin_low;

  // ----------------------------------------
  // Light-load pulse skipping
  // ----------------------------------------
  logic skip_q;
  // off below current floor, on when node sags
  always_ff @(posedge clk) begin
    if (reset || !boosting) begin
      skip_q <= 1'b0;
    end else if (ilow_s) begin
      skip_q <= 1'b1;
    end else if (node_low_s) begin
      skip_q <= 1'b0;
    end
  end
  assign boost_switch_on = boosting && !boost_fault && !skip_q;

  // ----------------------------------------
  // Parameters, limits and 15-minute timer
  // ----------------------------------------
  // one-cycle restore, then self-clear
  assign params_to_default = param_reset_bit;
  assign param_reset_clear = param_reset_bit;
  logic locked_q;
  always_ff @(posedge clk) begin
    if (reset || !lock_n_s) begin
      locked_q <= 1'b0;
    end else if (other_write) begin
      locked_q <= 1'b1;
    end
  end
  assign limits_to_default = !lock_n_s;
  assign safety_write_enable = lock_n_s && !locked_q && safety_write;
  logic cd_prev_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      cd_prev_q <= 1'b0;
    end else begin
      cd_prev_q <= cd_s;
    end
  end
  // rising disable resets only the 15-minute timer, and only when host_mode is low
  assign min15_timer_reset = cd_s && !cd_prev_q && !host_mode;
endmodule : cmf_ctrl

// ---- testbench/cmf_ctrl_chk.sv ----
// Purpose: Port assertions for the charger mode and fault controller
// Assumes: Pins pass a two-flop sync before they act
// Notes: Bound to every cmf_ctrl with its pulse and overload counts
`timescale 1ns/10ps
module cmf_ctrl_chk
  import cmf_pkg::*;
#(
  parameter int PULSE_US_P = PULSE_US,
  parameter int OVLD_US_P = OVLD_US
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic state_pin_enable,
  input wire logic high_impedance_select,
  input wire logic host_mode,
  input wire logic watchdog_kick_bit,
  input wire logic param_reset_bit,
  input wire logic other_write,
  input wire logic charge_disable_pin,
  input wire logic limit_lock_reset_pin,
  input wire logic output_overload,
  input wire logic bat_below_min,
  input wire logic state_pin_out,
  input wire logic state_pin_oe,
  input wire logic [1:0] op_mode,
  input wire logic charge_enable,
  input wire logic boost_switch_on,
  input wire logic watchdog_kick_clear,
  input wire logic param_reset_clear,
  input wire logic params_to_default,
  input wire logic safety_write_enable,
  input wire logic limits_to_default,
  input wire logic [3:0] fault_status
);
  int pw_q;
  int ol_q;
  logic wr_q;
  // ----------------------------------------
  // Run lengths; a restarted pulse would need a looser width bound
  // ----------------------------------------
  always_ff @(posedge clk) begin
    pw_q <= (state_pin_oe && !state_pin_enable) ? pw_q + 1 : 0;
    ol_q <= output_overload ? ol_q + 1 : 0;
    wr_q <= reset ? 1'b0 : (wr_q | (other_write & limit_lock_reset_pin));
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_pin_pulls_low: assert property (state_pin_oe |-> !state_pin_out)
    else $error("state pin driven high");
  a_pulse_width: assert property (pw_q <= (PULSE_US_P + 1) * TICK_CYCLES)
    else $error("fault pulse too long");
  a_hiz_bit: assert property (high_impedance_select [*4] |-> op_mode == CMF_HIZ)
    else $error("hi-z select ignored");
  a_disable_hiz: assert property (charge_disable_pin [*6] |->
    op_mode == CMF_HIZ && !charge_enable)
    else $error("charge disable pin ignored");
  a_param_reset: assert property (param_reset_bit |->
    param_reset_clear && params_to_default)
    else $error("parameter reset not applied");
  a_kick_clear: assert property (watchdog_kick_bit |-> watchdog_kick_clear)
    else $error("kick bit not cleared");
  a_lock_default: assert property (!limit_lock_reset_pin [*3] |->
    limits_to_default && !safety_write_enable)
    else $error("limits not held at default");
  a_lock_after: assert property (wr_q |-> !safety_write_enable)
    else $error("limit write after lock");
  a_ovld_persist: assert property ($rose(fault_status == FLT_OVLD) |->
    ol_q >= (OVLD_US_P - 1) * TICK_CYCLES)
    else $error("overload fault too early");
  a_bat_stop: assert property ($rose(bat_below_min) && op_mode == CMF_BOOST |->
    ##[1:6] !boost_switch_on)
    else $error("boost kept on low battery");
endmodule : cmf_ctrl_chk
bind cmf_ctrl cmf_ctrl_chk #(.PULSE_US_P(PULSE_US_P), .OVLD_US_P(OVLD_US_P)) chk (.*);

// ---- testbench/cmf_host.sv ----
// Purpose: Host processor model owning the written control bits
// Assumes: hreq bits are one-cycle requests
// Notes: 0 boost request, 1 watchdog kick, 2 parameter reset, 3 fault clear
`timescale 1ns/10ps
module cmf_host (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] hreq,
  input wire logic state_pin_oe,
  input wire logic clear_operation_select,
  input wire logic watchdog_kick_clear,
  input wire logic param_reset_clear,
  output logic operation_select_bit,
  output logic watchdog_kick_bit,
  output logic param_reset_bit,
  output logic fault_clear,
  output logic status_read
);
  logic oe_q;
  always_ff @(posedge clk) begin
    oe_q <= state_pin_oe;
    // status read as the pulse ends
    status_read <= !reset & oe_q & !state_pin_oe;
    fault_clear <= !reset & hreq[3];
    // kick held one cycle, until watchdog_kick_clear echoes it
    watchdog_kick_bit <= !reset & !watchdog_kick_clear & (watchdog_kick_bit | hreq[1]);
    param_reset_bit <= !reset & !param_reset_clear & (param_reset_bit | hreq[2]);
    operation_select_bit <= !reset & !clear_operation_select & (operation_select_bit | hreq[0]);
  end
endmodule : cmf_host

// ---- testbench/testbench.sv ----
// Purpose: Self-checking bench for the charger mode and fault controller
// Assumes: Short pulse, overload and watchdog counts
// Notes: Drivers note expectations; the monitor compares them in order
`timescale 1ns/10ps
module testbench;
  import cmf_pkg::*;
  localparam int PW = 4;
  localparam int OV = 50;
  localparam int WD = 200;
  localparam int CYC = PW * TICK_CYCLES;
  typedef struct packed {logic [2:0] kind; logic [3:0] val;} cmf_note_t;
  logic clk = 0, reset = 1, state_pin_enable = 0, charge_inhibit = 0, host_mode = 1;
  logic high_impedance_select = 0, otg_function_enable = 0, otg_pin = 0, safety_write = 0;
  logic other_write = 0, charge_disable_pin = 0, limit_lock_reset_pin = 1, vbus_above_uvlo = 1;
  logic look = 0;
  logic m15 = 1'b0;
  logic [11:0] fi = '0;
  logic [3:0] hreq = '0;
  logic operation_select_bit, watchdog_kick_bit, param_reset_bit, fault_clear, status_read;
  logic state_pin_out, state_pin_oe, charge_enable, boost_switch_on, clear_operation_select;
  logic watchdog_kick_clear, param_reset_clear, params_to_default, safety_write_enable;
  logic limits_to_default, min15_timer_reset;
  logic [1:0] op_mode;
  logic [3:0] fault_status;
  logic [31:0] seed = 32'h00014238;
  logic [3:0] ccode [7] = '{FLT_TIMER, FLT_SLEEP, FLT_OVP, FLT_OVP, FLT_POOR, FLT_NOBAT,
    FLT_THERM};
  cmf_note_t notes[$];
  cmf_note_t n;
  int num_errors = 0;
  int comparisons = 0;
  int w = 0;
  int r;
  cmf_ctrl #(.PULSE_US_P(PW), .OVLD_US_P(OV), .WDOG_US_P(WD)) DUT (
    .chg_timer_expired(fi[0]), .sleep_det(fi[1]), .vbus_ovp(fi[2]), .bat_ovp(fi[3]),
    .poor_source(fi[4]), .no_battery(fi[5]), .thermal_shutdown(fi[6]),
    .output_overload(fi[7]), .bat_above_max(fi[8]), .bat_below_min(fi[9]),
    .ind_current_low(fi[10]), .boost_node_low(fi[11]), .*);
  cmf_host host (.*);
  always #5 clk = ~clk;
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task step(input int c);
    repeat (c) @(posedge clk);
  endtask : step
  task end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  task bad(input string nm, input logic [3:0] e, input logic [3:0] g);
    $display("BAD %s expected %h seen %h", nm, e, g);
    num_errors++;
  endtask : bad
  task chk_mode(input logic [1:0] e);
    comparisons++;
    if (op_mode !== e) bad("op_mode", {2'b00, e}, {2'b00, op_mode});
  endtask : chk_mode
  task chk_flt(input logic [3:0] e);
    comparisons++;
    if (fault_status !== e) bad("fault_status", e, fault_status);
  endtask : chk_flt
  task chk_bit(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e) bad(nm, {3'b000, e}, {3'b000, g});
  endtask : chk_bit
  task note(input logic [2:0] k, input logic [3:0] v);
    notes.push_back({k, v});
    look <= 1'b1;
    step(1);
    look <= 1'b0;
    step(1);
  endtask : note
  task hr(input int b);
    hreq[b] <= 1'b1;
    step(1);
    hreq <= '0;
    step(1);
  endtask : hr
  task sw_try(input logic e);
    safety_write <= 1'b1;
    notes.push_back({3'd4, 3'b000, e});
    look <= 1'b1;
    step(1);
    safety_write <= 1'b0;
    look <= 1'b0;
    step(1);
  endtask : sw_try
  task wait_oe(input logic v, input int lim);
    int i;
    for (i = 0; i < lim && state_pin_oe !== v; i++) step(1);
    if (i == lim) begin
      bad("state_pin_oe wait", {3'b000, v}, {3'b000, state_pin_oe});
      end_sim();
    end
  endtask : wait_oe
  task fault_cycle(input int k, input logic [3:0] code, input int mode);
    // Code 12 drops the input supply; 13 and above raise no input at all
    if (k < 12) fi[k] <= 1'b1;
    else if (k == 12) vbus_above_uvlo <= 1'b0;
    wait_oe(1'b1, 40);
    step(4);
    note(3'd1, code);
    if (mode < 4) note(3'd0, mode[3:0]);
    else note(3'd3, 4'h0);
    fi <= '0;
    vbus_above_uvlo <= 1'b1;
    wait_oe(1'b0, CYC + 200);
  endtask : fault_cycle
  // ----------------------------------------
  // Monitor: pulse width and noted results
  // ----------------------------------------
  always @(posedge clk) begin
    if (state_pin_enable) w = 0;
    else if (state_pin_oe === 1'b1) w = w + 1;
    else if (w > 0) begin
      chk_bit("pulse width", 1'b1, w >= CYC - TICK_CYCLES && w <= CYC + TICK_CYCLES);
      w = 0;
    end
    if (min15_timer_reset === 1'b1) m15 = 1'b1;
    if (look) begin
      n = notes.pop_front();
      case (n.kind)
        3'd0: chk_mode(n.val[1:0]);
        3'd1: chk_flt(n.val);
        3'd2: chk_bit("state_pin_oe", n.val[0], state_pin_oe);
        3'd3: chk_bit("boost_switch_on", n.val[0], boost_switch_on);
        3'd5: begin
          chk_bit("min15_timer_reset", n.val[0], m15);
          m15 = 1'b0;
        end
        default: chk_bit("safety_write_enable", n.val[0], safety_write_enable);
      endcase
    end
  end
  initial begin
    step(95000);
    bad("run length", 4'h0, 4'h1);
    end_sim();
  end
  initial begin
    step(20);
    reset <= 1'b0;
    step(10);
    otg_pin <= 1'b1;
    step(8);
    note(3'd0, {2'b00, CMF_CHARGE});
    otg_pin <= 1'b0;
    state_pin_enable <= 1'b1;
    step(6);
    note(3'd2, 4'h1);
    charge_inhibit <= 1'b1;
    step(6);
    note(3'd2, 4'h0);
    {charge_inhibit, state_pin_enable, high_impedance_select} <= 3'b001;
    step(6);
    note(3'd0, {2'b00, CMF_HIZ});
    hr(2);
    {high_impedance_select, charge_disable_pin} <= 2'b01;
    step(8);
    note(3'd0, {2'b00, CMF_HIZ});
    note(3'd5, 4'h0);
    charge_disable_pin <= 1'b0;
    step(8);
    note(3'd0, {2'b00, CMF_CHARGE});
    {host_mode, charge_disable_pin} <= 2'b01;
    step(8);
    note(3'd5, 4'h1);
    {host_mode, charge_disable_pin} <= 2'b10;
    step(8);
    limit_lock_reset_pin <= 1'b0;
    step(5);
    sw_try(1'b0);
    limit_lock_reset_pin <= 1'b1;
    step(5);
    sw_try(1'b1);
    other_write <= 1'b1;
    step(1);
    other_write <= 1'b0;
    sw_try(1'b0);
    $display("mode, pin and lock tests done");
    r = int'(rnd() % 8);
    for (int j = 0; j < 8; j++) begin
      fault_cycle((j + r) % 8 == 7 ? 12 : (j + r) % 8, (j + r) % 8 == 7 ? FLT_UVLO :
        ccode[(j + r) % 8], (j + r) % 8 == 7 ? 0 : 3);
      hr(3);
      step(8);
      note(3'd0, {2'b00, CMF_CHARGE});
    end
    $display("charge fault tests done");
    hr(0);
    step(10);
    note(3'd3, 4'h1);
    note(3'd2, 4'h0);
    repeat (2) begin
      step(150 * TICK_CYCLES);
      hr(1);
    end
    note(3'd0, {2'b00, CMF_BOOST});
    wait_oe(1'b1, WD * TICK_CYCLES + 500);
    fi <= '0;
    fault_cycle(13, FLT_TIMER, 4);
    hr(3);
    hr(0);
    step(10);
    note(3'd3, 4'h1);
    r = 10 + int'(rnd() % 30);
    fi[7] <= 1'b1;
    step(r * TICK_CYCLES);
    fi[7] <= 1'b0;
    step(10);
    note(3'd3, 4'h1);
    fi[7] <= 1'b1;
    wait_oe(1'b1, OV * TICK_CYCLES + 500);
    fault_cycle(7, FLT_OVLD, 4);
    hr(0);
    step(10);
    note(3'd3, 4'h0);
    hr(3);
    hr(0);
    step(10);
    note(3'd3, 4'h1);
    fault_cycle(9, FLT_BAT, 4);
    step(10);
    note(3'd3, 4'h0);
    hr(0);
    step(10);
    fault_cycle(2, FLT_OVP, 4);
    {otg_function_enable, otg_pin} <= 2'b11;
    step(10);
    note(3'd3, 4'h1);
    $display("boost tests done");
    end_sim();
  end
endmodule : testbench
